// ---- core/pdm_pkg.sv ----
// constants, field layouts and carrier types of the pin-driver mode control
package pdm_pkg;

    localparam int CH_NUM  = 2;
    localparam int LVL_NUM = 10;
    localparam int LVL_W   = 14;

    // apb map: bit 6 of the byte address selects the channel
    localparam int         ADDR_W        = 8;
    localparam int         CH_SEL_BIT    = 6;
    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_CAL       = 6'h04;
    localparam logic [5:0] OFF_STAT      = 6'h08;
    localparam logic [5:0] OFF_LVL_FIRST = 6'h10;
    localparam logic [5:0] OFF_LVL_LAST  = 6'h34;

    // control register fields
    localparam int CTRL_LLEAK = 0;
    localparam int CTRL_TERM_MODE_SELECT = 1;
    localparam int CTRL_LOAD_DISABLE = 2;
    localparam int CTRL_LOAD_CAL_ENABLE = 3;
    localparam int CTRL_SLEW  = 4;
    localparam int CTRL_COMP_HYSTERESIS  = 8;

    // calibration register fields
    localparam int CAL_ORES   = 0;
    localparam int CAL_DROOP  = 4;
    localparam int CAL_CDROOP = 8;
    localparam int CAL_LONGTC = 12;
    localparam int CAL_SHRTTC = 16;

    // status register fields
    localparam int STAT_LEAK    = 0;
    localparam int STAT_LEAKPIN = 1;
    localparam int STAT_CLAMP   = 2;
    localparam int STAT_LOAD    = 3;
    localparam int STAT_CMPHI   = 4;
    localparam int STAT_CMPLO   = 5;

    // values after reset
    localparam logic [1:0]       SLEW_RST  = 2'h0;
    localparam logic [2:0]       COMP_HYSTERESIS_RST  = 3'h0;
    localparam logic [2:0]       DROOP_RST = 3'h0;
    localparam logic [3:0]       ORES_RST  = 4'h8;
    localparam logic [2:0]       TC_RST    = 3'h0;
    localparam logic [LVL_W-1:0] LVL_RST   = 14'h0000;

    typedef enum logic [1:0] {
        SRC_HIZ  = 2'b00,
        SRC_HIGH = 2'b01,
        SRC_LOW  = 2'b10,
        SRC_TERM = 2'b11
    } pdm_src_type;

    typedef struct packed {
        logic [2:0] compHysteresis;
        logic [1:0] slewSelect;
        logic       loadCalEnable;
        logic       loadDisable;
        logic       termModeSelect;
        logic       lowLeakSerialBit;
    } pdm_ctrl_type;

    typedef struct packed {
        logic [2:0] droopShortTc;
        logic [2:0] droopLongTc;
        logic [2:0] compDroopAmplitude;
        logic [2:0] droopAmplitude;
        logic [3:0] outResTrim;
    } pdm_cal_type;

    typedef struct packed {
        logic        lowLeak;
        pdm_src_type drvSource;
        logic        clampEnable;
        logic        loadEnable;
        logic [1:0]  slewSelect;
        logic [2:0]  compHysteresis;
        pdm_cal_type trim;
    } pdm_chan_out_type;

endpackage

// ---- core/pdm_mode_control.sv ----
// two-channel pin driver / comparator / load mode control with apb registers
`timescale 1ns/1ps
`default_nettype none

module pdm_mode_control
    import pdm_pkg::*;
(
    input  wire logic                                    mclk,
    input  wire logic                                    sys_rst,
    // apb slave
    input  wire logic [pdm_pkg::ADDR_W-1:0]              paddr,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [31:0]                             pwdata,
    output logic [31:0]                                  prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    // pins from outside the clock domain
    input  wire logic                                    resetPin_n,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              lowLeakPin_n,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              driveDataP,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              driveData_n,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              receiveCtlP,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              receiveCtl_n,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              pinAboveHigh,
    input  wire logic [pdm_pkg::CH_NUM-1:0]              pinAboveLow,
    // per-channel results
    output pdm_pkg::pdm_chan_out_type [pdm_pkg::CH_NUM-1:0] chanOut,
    output logic [pdm_pkg::CH_NUM-1:0][pdm_pkg::LVL_NUM-1:0][pdm_pkg::LVL_W-1:0]
                                                         levelCode,
    output logic [pdm_pkg::CH_NUM-1:0]                   highCompOutP,
    output logic [pdm_pkg::CH_NUM-1:0]                   highCompOut_n,
    output logic [pdm_pkg::CH_NUM-1:0]                   lowCompOutP,
    output logic [pdm_pkg::CH_NUM-1:0]                   lowCompOut_n
);

    import pdm_pkg::*;

    // synchronisers; first stage read only by the second
    logic                     rstPinMeta;
    logic                     rstPinSync;
    logic [CH_NUM-1:0]        leakPinMeta;
    logic [CH_NUM-1:0]        leakPinSync;
    logic [CH_NUM-1:0]        rcvPMeta;
    logic [CH_NUM-1:0]        rcvPSync;
    logic [CH_NUM-1:0]        rcvNMeta;
    logic [CH_NUM-1:0]        rcvNSync;
    logic [CH_NUM-1:0]        cmpHiMeta;
    logic [CH_NUM-1:0]        cmpHiSync;
    logic [CH_NUM-1:0]        cmpLoMeta;
    logic [CH_NUM-1:0]        cmpLoSync;

    logic                     pinRst;
    logic                     chSel;
    logic [5:0]               offset;
    logic                     isLevel;
    logic [3:0]               levelIdx;
    logic                     addrOk;
    logic                     wrEn;

    pdm_ctrl_type             ctrl [CH_NUM];
    pdm_cal_type              cal [CH_NUM];
    logic [LVL_W-1:0]         levels [CH_NUM][LVL_NUM];
    logic [31:0]              statWord [CH_NUM];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rstPinMeta <= 1'b1;
            rstPinSync <= 1'b1;
        end else begin
            rstPinMeta <= resetPin_n;
            rstPinSync <= rstPinMeta;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            leakPinMeta <= '1;
            leakPinSync <= '1;
            rcvPMeta    <= '0;
            rcvPSync    <= '0;
            rcvNMeta    <= '1;
            rcvNSync    <= '1;
            cmpHiMeta   <= '0;
            cmpHiSync   <= '0;
            cmpLoMeta   <= '0;
            cmpLoSync   <= '0;
        end else begin
            leakPinMeta <= lowLeakPin_n;
            leakPinSync <= leakPinMeta;
            rcvPMeta    <= receiveCtlP;
            rcvPSync    <= rcvPMeta;
            rcvNMeta    <= receiveCtl_n;
            rcvNSync    <= rcvNMeta;
            cmpHiMeta   <= pinAboveHigh;
            cmpHiSync   <= cmpHiMeta;
            cmpLoMeta   <= pinAboveLow;
            cmpLoSync   <= cmpLoMeta;
        end
    end

    // reset pin clears control and level codes, never the calibration
    assign pinRst = ~rstPinSync;

    // address decode
    assign chSel    = paddr[CH_SEL_BIT];
    assign offset   = paddr[5:0];
    assign isLevel  = (offset >= OFF_LVL_FIRST) && (offset <= OFF_LVL_LAST)
                      && (offset[1:0] == 2'b00);
    assign levelIdx = 4'((offset - OFF_LVL_FIRST) >> 2);
    assign addrOk   = (paddr[ADDR_W-1] == 1'b0) &&
                      ((offset == OFF_CTRL) || (offset == OFF_CAL) ||
                       (offset == OFF_STAT) || isLevel);
    assign wrEn     = psel && penable && pwrite && addrOk;

    // zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrOk;

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && addrOk) begin
            if (offset == OFF_CTRL) begin
                prdata[CTRL_LLEAK]      = ctrl[chSel].lowLeakSerialBit;
                prdata[CTRL_TERM_MODE_SELECT]      = ctrl[chSel].termModeSelect;
                prdata[CTRL_LOAD_DISABLE]      = ctrl[chSel].loadDisable;
                prdata[CTRL_LOAD_CAL_ENABLE]      = ctrl[chSel].loadCalEnable;
                prdata[CTRL_SLEW +: 2]  = ctrl[chSel].slewSelect;
                prdata[CTRL_COMP_HYSTERESIS +: 3]  = ctrl[chSel].compHysteresis;
            end else if (offset == OFF_CAL) begin
                prdata[CAL_ORES +: 4]   = cal[chSel].outResTrim;
                prdata[CAL_DROOP +: 3]  = cal[chSel].droopAmplitude;
                prdata[CAL_CDROOP +: 3] = cal[chSel].compDroopAmplitude;
                prdata[CAL_LONGTC +: 3] = cal[chSel].droopLongTc;
                prdata[CAL_SHRTTC +: 3] = cal[chSel].droopShortTc;
            end else if (offset == OFF_STAT) begin
                prdata = statWord[chSel];
            end else begin
                prdata[LVL_W-1:0] = levels[chSel][levelIdx];
            end
        end
    end

    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
        logic        wrCh;
        logic        leakNow;
        logic        leakSync;
        logic        dataHigh;
        logic        rcvOn;
        logic        rcvSync;
        pdm_src_type src;

        assign wrCh = wrEn && (chSel == 1'(c));

        // control register: power-up and reset pin both clear it
        always_ff @(posedge mclk) begin
            if (sys_rst || pinRst) begin
                ctrl[c].lowLeakSerialBit <= 1'b0;
                ctrl[c].termModeSelect   <= 1'b0;
                ctrl[c].loadDisable      <= 1'b0;
                ctrl[c].loadCalEnable    <= 1'b0;
                ctrl[c].slewSelect       <= SLEW_RST;
                ctrl[c].compHysteresis   <= COMP_HYSTERESIS_RST;
            end else if (wrCh && offset == OFF_CTRL) begin
                ctrl[c].lowLeakSerialBit <= pwdata[CTRL_LLEAK];
                ctrl[c].termModeSelect   <= pwdata[CTRL_TERM_MODE_SELECT];
                ctrl[c].loadDisable      <= pwdata[CTRL_LOAD_DISABLE];
                ctrl[c].loadCalEnable    <= pwdata[CTRL_LOAD_CAL_ENABLE];
                ctrl[c].slewSelect       <= pwdata[CTRL_SLEW +: 2];
                ctrl[c].compHysteresis   <= pwdata[CTRL_COMP_HYSTERESIS +: 3];
            end
        end

        // calibration register survives the reset pin
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                cal[c].outResTrim         <= ORES_RST;
                cal[c].droopAmplitude     <= DROOP_RST;
                cal[c].compDroopAmplitude <= DROOP_RST;
                cal[c].droopLongTc        <= TC_RST;
                cal[c].droopShortTc       <= TC_RST;
            end else if (wrCh && offset == OFF_CAL) begin
                cal[c].outResTrim         <= pwdata[CAL_ORES +: 4];
                cal[c].droopAmplitude     <= pwdata[CAL_DROOP +: 3];
                cal[c].compDroopAmplitude <= pwdata[CAL_CDROOP +: 3];
                cal[c].droopLongTc        <= pwdata[CAL_LONGTC +: 3];
                cal[c].droopShortTc       <= pwdata[CAL_SHRTTC +: 3];
            end
        end

        for (genvar l = 0; l < LVL_NUM; l++) begin : g_lvl
            always_ff @(posedge mclk) begin
                if (sys_rst || pinRst) begin
                    levels[c][l] <= LVL_RST;
                end else if (wrCh && isLevel && levelIdx == 4'(l)) begin
                    levels[c][l] <= pwdata[LVL_W-1:0];
                end
            end
            assign levelCode[c][l] = levels[c][l];
        end

        // the pin acts combinationally so a low level needs no clock edge;
        // the serial bit holds the channel regardless of everything else
        assign leakNow  = ~lowLeakPin_n[c] | ctrl[c].lowLeakSerialBit;
        assign leakSync = ~leakPinSync[c] | ctrl[c].lowLeakSerialBit;

        // differential pairs: asserted only while the pair is split high/low
        assign dataHigh = driveDataP[c] & ~driveData_n[c];
        assign rcvOn    = receiveCtlP[c] & ~receiveCtl_n[c];
        assign rcvSync  = rcvPSync[c] & ~rcvNSync[c];

        always_comb begin
            if (leakNow) begin
                src = SRC_HIZ;
            end else if (!rcvOn) begin
                src = dataHigh ? SRC_HIGH : SRC_LOW;
            end else if (ctrl[c].termModeSelect) begin
                src = SRC_TERM;
            end else begin
                src = SRC_HIZ;
            end
        end

        assign chanOut[c].lowLeak        = leakNow;
        assign chanOut[c].drvSource      = src;
        assign chanOut[c].clampEnable    = (src == SRC_HIZ) && !leakNow;
        // load-disable wins over load-cal; cal ignores the driver state
        assign chanOut[c].loadEnable     = !leakNow && !ctrl[c].loadDisable &&
                                           ((rcvOn && !ctrl[c].termModeSelect) ||
                                            ctrl[c].loadCalEnable);
        assign chanOut[c].slewSelect     = ctrl[c].slewSelect;
        assign chanOut[c].compHysteresis = ctrl[c].compHysteresis;
        assign chanOut[c].trim           = cal[c];

        // window comparator flags, synchronised and registered
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                highCompOutP[c]  <= 1'b0;
                highCompOut_n[c] <= 1'b1;
                lowCompOutP[c]   <= 1'b0;
                lowCompOut_n[c]  <= 1'b1;
            end else begin
                highCompOutP[c]  <= cmpHiSync[c];
                highCompOut_n[c] <= ~cmpHiSync[c];
                lowCompOutP[c]   <= cmpLoSync[c];
                lowCompOut_n[c]  <= ~cmpLoSync[c];
            end
        end

        // status uses only synchronised copies so software never sees
        // a metastable bit
        always_comb begin
            statWord[c]               = 32'h0000_0000;
            statWord[c][STAT_LEAK]    = leakSync;
            statWord[c][STAT_LEAKPIN] = ~leakPinSync[c];
            statWord[c][STAT_CLAMP]   = !leakSync && rcvSync &&
                                        !ctrl[c].termModeSelect;
            statWord[c][STAT_LOAD]    = !leakSync && !ctrl[c].loadDisable &&
                                        ((rcvSync && !ctrl[c].termModeSelect) ||
                                         ctrl[c].loadCalEnable);
            statWord[c][STAT_CMPHI]   = highCompOutP[c];
            statWord[c][STAT_CMPLO]   = lowCompOutP[c];
        end
    end

endmodule // pdm_mode_control

`default_nettype wire

// ---- testbench/pdm_mode_monitor.sv ----
// assertion checker watching the mode-control top ports
`timescale 1ns/1ps
`default_nettype none
module pdm_mode_monitor (
    input wire logic                       mclk,
    input wire logic                       sys_rst,
    input wire logic                       resetPin_n,
    input wire logic [pdm_pkg::CH_NUM-1:0] lowLeakPin_n,
    input wire logic [pdm_pkg::CH_NUM-1:0] driveDataP,
    input wire logic [pdm_pkg::CH_NUM-1:0] driveData_n,
    input wire logic [pdm_pkg::CH_NUM-1:0] receiveCtlP,
    input wire logic [pdm_pkg::CH_NUM-1:0] receiveCtl_n,
    input wire logic [pdm_pkg::CH_NUM-1:0] pinAboveHigh,
    input wire logic [pdm_pkg::CH_NUM-1:0] pinAboveLow,
    input wire pdm_pkg::pdm_chan_out_type [pdm_pkg::CH_NUM-1:0] chanOut,
    input wire logic [pdm_pkg::CH_NUM-1:0] highCompOutP,
    input wire logic [pdm_pkg::CH_NUM-1:0] highCompOut_n,
    input wire logic [pdm_pkg::CH_NUM-1:0] lowCompOutP,
    input wire logic [pdm_pkg::CH_NUM-1:0] lowCompOut_n
);
    import pdm_pkg::*;
    logic [1:0] rcvOn;
    logic [1:0] datHi;
    logic [1:0] age;
    assign rcvOn = receiveCtlP & ~receiveCtl_n;
    assign datHi = driveDataP & ~driveData_n;
    // sync history is only trusted three edges after reset
    always_ff @(posedge mclk) begin
        if (sys_rst)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_leak_pin: assert property (
        !lowLeakPin_n[1] |-> chanOut[1].lowLeak)
        else $error("leak pin ignored");
    chk_leak_wins: assert property (
        chanOut[0].lowLeak |-> chanOut[0].drvSource == SRC_HIZ &&
        !chanOut[0].clampEnable && !chanOut[0].loadEnable)
        else $error("leak does not override");
    chk_drive_data: assert property (
        !chanOut[0].lowLeak && !rcvOn[0] |->
        chanOut[0].drvSource == (datHi[0] ? SRC_HIGH : SRC_LOW))
        else $error("drive source wrong");
    chk_rcv_mode: assert property (
        !chanOut[1].lowLeak && rcvOn[1] |->
        chanOut[1].drvSource inside {SRC_TERM, SRC_HIZ})
        else $error("receive source wrong");
    chk_clamp_hiz: assert property (
        chanOut[0].clampEnable ==
        (chanOut[0].drvSource == SRC_HIZ && !chanOut[0].lowLeak))
        else $error("clamp enable wrong");
    chk_chan_indep: assert property (
        $changed(lowLeakPin_n[0]) && $stable(lowLeakPin_n[1]) |->
        $stable(chanOut[1].lowLeak))
        else $error("channel leak coupled");
    chk_rst_vals: assert property (
        $fell(sys_rst) |-> chanOut[0].slewSelect == SLEW_RST &&
        chanOut[0].compHysteresis == COMP_HYSTERESIS_RST &&
        chanOut[0].trim.outResTrim == ORES_RST &&
        chanOut[0].trim.droopAmplitude == DROOP_RST)
        else $error("reset values wrong");
    chk_pin_rst: assert property (
        !resetPin_n [*4] |-> chanOut[0].slewSelect == 2'h0 &&
        chanOut[1].compHysteresis == 3'h0)
        else $error("reset pin ignored");
    chk_cmp_delay: assert property (
        age == 2'h3 |-> highCompOutP == $past(pinAboveHigh, 3) &&
        lowCompOutP == $past(pinAboveLow, 3))
        else $error("comparator flag wrong");
    chk_cmp_compl: assert property (
        highCompOut_n == ~highCompOutP && lowCompOut_n == ~lowCompOutP)
        else $error("comparator complement wrong");
    cov_term: cover property (chanOut[0].drvSource == SRC_TERM);
    cov_pin_leak: cover property (!lowLeakPin_n[1]);
    cov_cal_load: cover property (
        chanOut[0].loadEnable && chanOut[0].drvSource != SRC_HIZ);
endmodule // pdm_mode_monitor

bind pdm_mode_control pdm_mode_monitor u_pdm_mode_monitor (
    .mclk, .sys_rst, .resetPin_n, .lowLeakPin_n, .driveDataP,
    .driveData_n, .receiveCtlP, .receiveCtl_n, .pinAboveHigh,
    .pinAboveLow, .chanOut, .highCompOutP, .highCompOut_n,
    .lowCompOutP, .lowCompOut_n);
`default_nettype wire

// ---- testbench/pdm_tester_formatter.sv ----
// tester formatter model driving the differential pin pairs
`timescale 1ns/1ps
`default_nettype none
module pdm_tester_formatter (
    input wire logic [1:0] dataReq,
    input wire logic [1:0] rcvReq,
    output logic [1:0]     driveDataP,
    output logic [1:0]     driveData_n,
    output logic [1:0]     receiveCtlP,
    output logic [1:0]     receiveCtl_n
);
    // true pairs only; equal legs are never sent
    assign driveDataP   = dataReq;
    assign driveData_n  = ~dataReq;
    assign receiveCtlP  = rcvReq;
    assign receiveCtl_n = ~rcvReq;
endmodule // pdm_tester_formatter
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the pin-driver mode control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pdm_pkg::*;
    logic                  mclk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [7:0]            paddr = 8'h00;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  resetPin_n = 1'b1;
    logic [1:0]            lowLeakPin_n = 2'h3;
    logic [1:0]            dataReq = 2'h0;
    logic [1:0]            rcvReq = 2'h0;
    logic [1:0]            pinAboveHigh = 2'h0;
    logic [1:0]            pinAboveLow = 2'h0;
    logic [1:0]            dP, dN, rP, rN, hP, hN, lP, lN;
    pdm_chan_out_type [1:0] chanOut;
    logic [1:0][LVL_NUM-1:0][LVL_W-1:0] levelCode;
    logic [31:0]           seed = 32'h889b884d;
    logic [31:0]           rd;
    logic                  er;
    logic [31:0]           ctl [2] = '{32'h0, 32'h0};
    logic [31:0]           calv [2];
    int                    err_total = 0;
    int                    n_compared = 0;

    always #5 mclk = ~mclk;

    pdm_tester_formatter u_pdm_tester_formatter (.dataReq, .rcvReq,
        .driveDataP(dP), .driveData_n(dN), .receiveCtlP(rP),
        .receiveCtl_n(rN));
    pdm_mode_control u_pdm_mode_control (.mclk, .sys_rst, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .resetPin_n, .lowLeakPin_n, .driveDataP(dP), .driveData_n(dN),
        .receiveCtlP(rP), .receiveCtl_n(rN), .pinAboveHigh,
        .pinAboveLow, .chanOut, .levelCode, .highCompOutP(hP),
        .highCompOut_n(hN), .lowCompOutP(lP), .lowCompOut_n(lN));

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [4:0] mode_exp(logic pn, logic dat,
                                            logic rcv, logic [3:0] b);
        logic       lk;
        logic [1:0] s;
        lk = !pn | b[0];
        s = lk ? 2'h0 : !rcv ? (dat ? 2'h1 : 2'h2) : (b[1] ? 2'h3 : 2'h0);
        return {lk, s, s == 2'h0 && !lk,
                !lk && !b[2] && ((rcv && !b[1]) || b[3])};
    endfunction

    function automatic logic [15:0] trim_exp(logic [31:0] v);
        return {v[18:16], v[14:12], v[10:8], v[6:4], v[3:0]};
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // call just after a rising edge; returns at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // whole run is under two thousand cycles
    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic        c;
        logic [4:0]  m;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int k = 0; k < 2; k++) begin
            apb(1'b0, {1'b0, k[0], 6'h00}, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, {1'b0, k[0], 6'h04}, 32'h0);
            chk(rd, {28'h0, ORES_RST});
            calv[k] = xs() & 32'h00077777;
            apb(1'b1, {1'b0, k[0], 6'h04}, calv[k]);
            chk(chanOut[k].trim, trim_exp(calv[k]));
            for (int l = 0; l < LVL_NUM; l++) begin
                r = xs() & 32'h3fff;
                apb(1'b1, {1'b0, k[0], 6'h10 + 6'(4 * l)}, r);
                chk(levelCode[k][l], r);
                apb(1'b0, {1'b0, k[0], 6'h10 + 6'(4 * l)}, 32'h0);
                chk(rd, r);
            end
        end
        apb(1'b0, 8'h80, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        // aligned but unused offset inside a channel window
        apb(1'b0, 8'h4c, 32'h0);
        chk(er, 1'b1);
        $display("registers done");
        for (int i = 0; i < 80; i++) begin
            r = xs();
            c = r[31];
            lowLeakPin_n[c] <= r[0] | r[1];
            dataReq[c] <= r[2];
            rcvReq[c] <= r[3];
            pinAboveHigh[c] <= r[6];
            pinAboveLow[c] <= r[7];
            ctl[c] = xs() & 32'h0000073f;
            ctl[c][0] = r[4] & r[5];
            apb(1'b1, {1'b0, c, 6'h00}, ctl[c]);
            @(posedge mclk);
            for (int k = 0; k < 2; k++) begin
                chk({chanOut[k].lowLeak, chanOut[k].drvSource,
                     chanOut[k].clampEnable, chanOut[k].loadEnable},
                    mode_exp(lowLeakPin_n[k], dataReq[k], rcvReq[k],
                             ctl[k][3:0]));
                chk({chanOut[k].compHysteresis, chanOut[k].slewSelect},
                    {ctl[k][10:8], ctl[k][5:4]});
                chk({hP[k], hN[k], lP[k], lN[k]}, {pinAboveHigh[k],
                    ~pinAboveHigh[k], pinAboveLow[k],
                    ~pinAboveLow[k]});
            end
            // status is read through the synchronised copies
            apb(1'b0, {1'b0, c, 6'h08}, 32'h0);
            m = mode_exp(lowLeakPin_n[c], dataReq[c], rcvReq[c],
                         ctl[c][3:0]);
            chk(rd, {26'h0, pinAboveLow[c], pinAboveHigh[c], m[0], m[1],
                     !lowLeakPin_n[c], m[4]});
        end
        $display("mode table done");
        resetPin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 2; k++) begin
            chk({chanOut[k].compHysteresis, chanOut[k].slewSelect},
                5'h0);
            chk(chanOut[k].trim, trim_exp(calv[k]));
        end
        resetPin_n <= 1'b1;
        lowLeakPin_n <= 2'h3;
        repeat (3) @(posedge mclk);
        chk(chanOut[0].lowLeak, 1'b0);
        lowLeakPin_n <= 2'h2;
        #1 chk(chanOut[0].lowLeak, 1'b1);
        chk(chanOut[1].lowLeak, 1'b0);
        $display("reset pin and leak pin done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
